/* File: dv/twbcc_bus_model.sv */
// Behavioural model of the other party on the shared two-wire bus
`timescale 1ns/1ps
`default_nettype none
module twbcc_bus_model (
   input  wire logic scl_oe_i,
   input  wire logic sda_oe_i,
   input  wire logic frame_i,
   input  wire logic sda_low_i,
   output wire logic scl_o,
   output wire logic sda_o
);
   logic lclk_q = 1'b1;
   // Link clock toggles only inside a frame and idles high between frames
   always #40 lclk_q = frame_i ? ~lclk_q : 1'b1;
   // Open drain with pull-ups: a line nobody pulls reads high
   assign scl_o = ~(scl_oe_i | ~lclk_q);
   assign sda_o = ~(sda_oe_i | sda_low_i);
endmodule
`default_nettype wire

/* File: dv/twbcc_core_tb_top.sv */
// Self-checking testbench of the two-wire bus configuration block
`timescale 1ns/1ps
`default_nettype none
module twbcc_core_tb_top;
   import twbcc_pkg::*;
   logic       clk_sys_i = 1'b0;
   logic       arst_n_i  = 1'b0;
   logic [2:0] addr      = 3'h0;
   logic [7:0] wdata     = 8'h00;
   logic [7:0] rdata;
   logic [7:0] rd_v;
   logic       wr        = 1'b0;
   logic       rd        = 1'b0;
   logic       scl_req   = 1'b0;
   logic       sda_req   = 1'b0;
   logic [3:0] ev        = 4'h0;
   logic       frame     = 1'b0;
   logic       sda_low   = 1'b0;
   wire logic  scl_w;
   wire logic  sda_w;
   wire logic  scl_oe;
   wire logic  sda_oe;
   wire logic  busy;
   wire logic  irq;
   wire logic  scl_dv;
   wire logic  sda_dv;
   int         bad_count = 0;
   int         n_tests   = 0;
   int         n;

   always #4 clk_sys_i = ~clk_sys_i;

   twbcc_core i_dut (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i),
      .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
      .rdata_o(rdata), .scl_i(scl_w), .sda_i(sda_w), .scl_o(scl_dv),
      .scl_oe_o(scl_oe), .sda_o(sda_dv), .sda_oe_o(sda_oe),
      .scl_req_low_i(scl_req), .sda_req_low_i(sda_req),
      .bus_clk_tick_i(ev[0]), .tmr_tick_i(ev[1]), .slave_event_i(ev[2]),
      .master_event_i(ev[3]), .busy_o(busy), .irq_o(irq));

   twbcc_bus_model i_bus (.scl_oe_i(scl_oe), .sda_oe_i(sda_oe),
      .frame_i(frame), .sda_low_i(sda_low), .scl_o(scl_w), .sda_o(sda_w));

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk_sys_i);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk_sys_i);
      wr <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
      @(posedge clk_sys_i);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk_sys_i);
      rd <= 1'b0;
      #1;
      d = rdata;
   endtask

   // ev bits: 0 bus clock tick, 1 timer tick, 2 slave, 3 master event
   task automatic pulse(input int k, input int cnt);
      repeat (cnt) begin
         @(posedge clk_sys_i);
         ev[k] <= 1'b1;
         @(posedge clk_sys_i);
         ev[k] <= 1'b0;
      end
   endtask

   task automatic wait_busy(input logic v);
      int i;
      for (i = 0; i < 40 && busy !== v; i++) @(posedge clk_sys_i);
      #1;
      chk({7'h0, busy}, {7'h0, v});
      if (busy !== v) print_verdict();
   endtask

   // Counts cycles from a drive request to the SDA pull-down
   task automatic hold_cyc(input logic [7:0] cfg, input logic [3:0] exp);
      int i;
      wr_reg(ADDR_CFG, cfg);
      repeat (4) @(posedge clk_sys_i);
      sda_req <= 1'b1;
      i = 0;
      do begin
         @(posedge clk_sys_i);
         #1;
         i++;
      end while (sda_oe !== 1'b1 && i < 12);
      chk(8'(i), {4'h0, exp});
      if (sda_oe !== 1'b1) print_verdict();
      @(posedge clk_sys_i);
      sda_req <= 1'b0;
      repeat (12) @(posedge clk_sys_i);
   endtask

   initial begin
      repeat (16) @(posedge clk_sys_i);
      arst_n_i <= 1'b1;
      for (n = 0; n < 8; n++) begin
         rd_reg(3'(n), rd_v);
         chk(rd_v, 8'h00);
      end
      wr_reg(ADDR_CFG, 8'hff);
      rd_reg(ADDR_CFG, rd_v);
      chk(rd_v, CFG_RW_MASK);
      // Read data must fall back to zero in the cycle after it stood
      @(posedge clk_sys_i);
      #1;
      chk(rdata, 8'h00);
      wr_reg(ADDR_CFG, 8'h00);
      scl_req <= 1'b1;
      sda_req <= 1'b1;
      sda_low <= 1'b1;
      repeat (8) @(posedge clk_sys_i);
      chk({6'h0, scl_oe, sda_oe}, 8'h00);
      chk({6'h0, scl_dv, sda_dv}, 8'h00);
      chk({7'h0, busy}, 8'h00);
      scl_req <= 1'b0;
      sda_req <= 1'b0;
      sda_low <= 1'b0;
      wr_reg(ADDR_CFG, 8'h80);
      repeat (8) @(posedge clk_sys_i);
      sda_low <= 1'b1;
      wait_busy(1'b1);
      rd_reg(ADDR_CFG, rd_v);
      chk(rd_v, 8'ha0);
      @(posedge clk_sys_i);
      sda_low <= 1'b0;
      wait_busy(1'b0);
      hold_cyc(8'h80, HOLD_NORM_CYC);
      hold_cyc(8'h90, HOLD_EXT_CYC);
      // Bus free after a frame that ends without a stop
      wr_reg(ADDR_MASK, 8'h08);
      wr_reg(ADDR_CFG, 8'h84);
      sda_low <= 1'b1;
      wait_busy(1'b1);
      frame <= 1'b1;
      for (n = 0; n < 40 && scl_w !== 1'b0; n++) @(posedge clk_sys_i);
      chk({7'h0, scl_w}, 8'h00);
      if (scl_w !== 1'b0) print_verdict();
      sda_low <= 1'b0;
      repeat (4) @(posedge clk_sys_i);
      frame <= 1'b0;
      repeat (20) @(posedge clk_sys_i);
      pulse(0, 10);
      repeat (4) @(posedge clk_sys_i);
      chk({7'h0, busy}, 8'h01);
      pulse(0, 1);
      wait_busy(1'b0);
      repeat (3) @(posedge clk_sys_i);
      chk({7'h0, irq}, 8'h01);
      rd_reg(ADDR_STAT, rd_v);
      chk(rd_v, 8'h08);
      wr_reg(ADDR_STAT, 8'h08);
      repeat (3) @(posedge clk_sys_i);
      chk({7'h0, irq}, 8'h00);
      // Slave events silenced, master events kept
      wr_reg(ADDR_CFG, 8'hc0);
      pulse(2, 1);
      pulse(3, 1);
      rd_reg(ADDR_STAT, rd_v);
      chk(rd_v, 8'h02);
      wr_reg(ADDR_CFG, 8'h80);
      pulse(2, 1);
      rd_reg(ADDR_STAT, rd_v);
      chk(rd_v, 8'h03);
      chk({7'h0, irq}, 8'h00);
      wr_reg(ADDR_STAT, 8'h0f);
      // Software sets the timeout period through the reload value
      wr_reg(ADDR_TCTL, 8'h03);
      wr_reg(ADDR_RLD_HI, 8'hff);
      wr_reg(ADDR_RLD_LO, 8'h00);
      wr_reg(ADDR_CFG, 8'h88);
      pulse(1, 3);
      rd_reg(ADDR_TMR_LO, rd_v);
      chk(rd_v, 8'h03);
      rd_reg(ADDR_STAT, rd_v);
      chk(rd_v, 8'h00);
      wr_reg(ADDR_TCTL, 8'h01);
      wr_reg(ADDR_RLD_LO, 8'hfe);
      pulse(1, 3);
      rd_reg(ADDR_TMR_LO, rd_v);
      chk(rd_v, 8'hfe);
      @(posedge clk_sys_i);
      scl_req <= 1'b1;
      repeat (8) @(posedge clk_sys_i);
      pulse(1, 1);
      rd_reg(ADDR_STAT, rd_v);
      chk(rd_v, 8'h00);
      pulse(1, 1);
      rd_reg(ADDR_STAT, rd_v);
      chk(rd_v, 8'h04);
      @(posedge clk_sys_i);
      scl_req <= 1'b0;
      repeat (8) @(posedge clk_sys_i);
      print_verdict();
   end
endmodule
`default_nettype wire

/* File: inc/twbcc_pkg.sv */
// Constants for the two-wire bus configuration and control block
package twbcc_pkg;
   // Register map, word index on the 3-bit port address
   localparam logic [2:0] ADDR_CFG      = 3'h0;
   localparam logic [2:0] ADDR_STAT     = 3'h1;
   localparam logic [2:0] ADDR_MASK     = 3'h2;
   localparam logic [2:0] ADDR_TCTL     = 3'h3;
   localparam logic [2:0] ADDR_RLD_LO   = 3'h4;
   localparam logic [2:0] ADDR_RLD_HI   = 3'h5;
   localparam logic [2:0] ADDR_TMR_LO   = 3'h6;
   localparam logic [2:0] ADDR_TMR_HI   = 3'h7;
   // bus_configuration fields
   localparam int CFG_EN    = 7;
   localparam int CFG_INH   = 6;
   localparam int CFG_BUSY  = 5;
   localparam int CFG_EXTH  = 4;
   localparam int CFG_TOE   = 3;
   localparam int CFG_FTE   = 2;
   localparam logic [7:0] CFG_RW_MASK = 8'hdf;
   localparam logic [7:0] CFG_RESET   = 8'h00;
   // Timer control fields
   localparam int TCTL_RUN   = 0;
   localparam int TCTL_SPLIT = 1;
   localparam logic [1:0] TCTL_RESET = 2'h0;
   localparam logic [7:0] RLD_RESET  = 8'h00;
   // Interrupt status and mask fields
   localparam int IRQ_W      = 4;
   localparam int IRQ_SLAVE  = 0;
   localparam int IRQ_MASTER = 1;
   localparam int IRQ_SCLTO  = 2;
   localparam int IRQ_FREE   = 3;
   localparam logic [IRQ_W-1:0] IRQ_RESET = 4'h0;
   // Bus-free detection: free after more than this many source periods
   localparam logic [3:0] FREE_PERIODS = 4'ha;
   // SDA setup/hold, in system clock cycles
   localparam logic [3:0] HOLD_NORM_CYC = 4'h2;
   localparam logic [3:0] HOLD_EXT_CYC  = 4'h6;
endpackage

/* File: rtl/twbcc_core.sv */
// Two-wire bus configuration, busy, timeout and free detection logic
//
// Chosen here: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
// Function
// - Enable (bit 7) set keeps the block active, watching SDA and SCL.
// - Slave-inhibit (bit 6) masks slave event interrupts, master ones stay.
// - Hardware sets the read-only busy bit (bit 5) during a bus transfer.
// - Busy clears when a STOP or a bus-free timeout is seen.
// - Bit 4 picks normal (0) or extended (1) SDA setup and hold times.
// - With bit 3 set the timer reloads while SCL is high, counts while low.
// - In split mode only the high byte is held in reload while SCL is high.
// - Bit 2 set: bus is free once SCL and SDA stay high over 10 periods.
// - SCL-low timeout is the timer high overflow, 16-bit or split high byte.
module twbcc_core
   import twbcc_pkg::*;
(
   input  wire logic                 clk_sys_i,
   input  wire logic                 arst_n_i,
   input  wire logic [2:0]           addr_i,
   input  wire logic [7:0]           wdata_i,
   input  wire logic                 wr_i,
   input  wire logic                 rd_i,
   output var  logic [7:0]           rdata_o,
   input  wire logic                 scl_i,
   input  wire logic                 sda_i,
   output var  logic                 scl_o,
   output var  logic                 scl_oe_o,
   output var  logic                 sda_o,
   output var  logic                 sda_oe_o,
   input  wire logic                 scl_req_low_i,
   input  wire logic                 sda_req_low_i,
   input  wire logic                 bus_clk_tick_i,
   input  wire logic                 tmr_tick_i,
   input  wire logic                 slave_event_i,
   input  wire logic                 master_event_i,
   output var  logic                 busy_o,
   output var  logic                 irq_o
);
   import twbcc_pkg::*;

   default clocking cb_sys @(posedge clk_sys_i);
   endclocking
   default disable iff (!arst_n_i);

   function automatic logic [IRQ_W-1:0] w1c(input logic [IRQ_W-1:0] cur,
                                            input logic [IRQ_W-1:0] clr,
                                            input logic [IRQ_W-1:0] set);
      w1c = (cur & ~clr) | set;
   endfunction

   logic [7:0]       cfg_q;
   logic [1:0]       tctl_q;
   logic [7:0]       rld_lo_q;
   logic [7:0]       rld_hi_q;
   logic [15:0]      tmr_q;
   logic [IRQ_W-1:0] stat_q;
   logic [IRQ_W-1:0] mask_q;
   logic [IRQ_W-1:0] stat_set;
   logic [IRQ_W-1:0] stat_clr;
   logic             scl_s1_q, scl_s2_q, scl_s3_q;
   logic             sda_s1_q, sda_s2_q, sda_s3_q;
   logic             busy_q;
   logic [3:0]       free_cnt_q;
   logic [3:0]       hold_cnt_q;
   logic [3:0]       hold_lim;
   logic             en, start_det, stop_det, free_pls, hi_ovf;
   logic             lo_ovf, force_rld, wr_cfg;

   assign en       = cfg_q[CFG_EN];
   assign wr_cfg   = wr_i && (addr_i == ADDR_CFG);

   // Two-flop synchronisers; the third stage only feeds edge detection
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         scl_s1_q <= 1'b1;
         scl_s2_q <= 1'b1;
         scl_s3_q <= 1'b1;
         sda_s1_q <= 1'b1;
         sda_s2_q <= 1'b1;
         sda_s3_q <= 1'b1;
      end else begin
         scl_s1_q <= scl_i;
         scl_s2_q <= scl_s1_q;
         scl_s3_q <= scl_s2_q;
         sda_s1_q <= sda_i;
         sda_s2_q <= sda_s1_q;
         sda_s3_q <= sda_s2_q;
      end
   end

   // START and STOP are only looked for while enabled
   assign start_det = en && scl_s2_q && scl_s3_q
                      && sda_s3_q && !sda_s2_q;
   assign stop_det  = en && scl_s2_q && scl_s3_q
                      && !sda_s3_q && sda_s2_q;

   // Configuration register; busy is not writable
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cfg_q <= CFG_RESET;
      end else if (wr_cfg) begin
         cfg_q <= wdata_i & CFG_RW_MASK;
      end
   end

   // Timer control, reload and interrupt mask registers
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         tctl_q   <= TCTL_RESET;
         rld_lo_q <= RLD_RESET;
         rld_hi_q <= RLD_RESET;
         mask_q   <= IRQ_RESET;
      end else if (wr_i) begin
         case (addr_i)
            ADDR_TCTL:   tctl_q   <= wdata_i[1:0];
            ADDR_RLD_LO: rld_lo_q <= wdata_i;
            ADDR_RLD_HI: rld_hi_q <= wdata_i;
            ADDR_MASK:   mask_q   <= wdata_i[IRQ_W-1:0];
            default: ;
         endcase
      end
   end

   // Busy: set on START, cleared on STOP or free timeout
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         busy_q <= 1'b0;
      end else if (!en) begin
         busy_q <= 1'b0;
      end else if (start_det) begin
         busy_q <= 1'b1;
      end else if (stop_det || free_pls) begin
         busy_q <= 1'b0;
      end
   end

   // Bus-free counter runs on the selected bus clock source tick
   assign free_pls = en && cfg_q[CFG_FTE] && scl_s2_q && sda_s2_q
                     && bus_clk_tick_i && (free_cnt_q == FREE_PERIODS);

   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         free_cnt_q <= 4'h0;
      end else if (!(en && cfg_q[CFG_FTE] && scl_s2_q && sda_s2_q)) begin
         free_cnt_q <= 4'h0;
      end else if (bus_clk_tick_i && free_cnt_q <= FREE_PERIODS) begin
         free_cnt_q <= free_cnt_q + 4'h1;
      end
   end

   // Timeout timer: 16-bit or two 8-bit halves, each auto-reloading
   assign force_rld = en && cfg_q[CFG_TOE] && scl_s2_q;
   assign lo_ovf    = tctl_q[TCTL_RUN] && tmr_tick_i && (tmr_q[7:0] == 8'hff);
   assign hi_ovf    = tctl_q[TCTL_RUN] && tmr_tick_i && !force_rld
                      && (tmr_q[15:8] == 8'hff)
                      && (tctl_q[TCTL_SPLIT] || tmr_q[7:0] == 8'hff);

   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         tmr_q <= 16'h0000;
      end else if (force_rld && !tctl_q[TCTL_SPLIT]) begin
         tmr_q <= {rld_hi_q, rld_lo_q};
      end else begin
         if (force_rld) begin
            tmr_q[15:8] <= rld_hi_q;
         end else if (hi_ovf) begin
            tmr_q[15:8] <= rld_hi_q;
         end else if (tctl_q[TCTL_RUN] && tmr_tick_i
                      && (tctl_q[TCTL_SPLIT] || lo_ovf)) begin
            tmr_q[15:8] <= tmr_q[15:8] + 8'h01;
         end
         if (lo_ovf) begin
            tmr_q[7:0] <= rld_lo_q;
         end else if (tctl_q[TCTL_RUN] && tmr_tick_i) begin
            tmr_q[7:0] <= tmr_q[7:0] + 8'h01;
         end
      end
   end

   // Sticky status; a set in the clearing cycle wins
   always_comb begin
      stat_set             = '0;
      stat_set[IRQ_SLAVE]  = en && slave_event_i && !cfg_q[CFG_INH];
      stat_set[IRQ_MASTER] = en && master_event_i;
      stat_set[IRQ_SCLTO]  = hi_ovf;
      stat_set[IRQ_FREE]   = free_pls;
      stat_clr = (wr_i && addr_i == ADDR_STAT) ? wdata_i[IRQ_W-1:0] : '0;
   end

   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         stat_q <= IRQ_RESET;
         irq_o  <= 1'b0;
      end else begin
         stat_q <= w1c(stat_q, stat_clr, stat_set);
         irq_o  <= |(stat_q & mask_q);
      end
   end

   // SDA drive changes wait out the setup/hold time before reaching the pin
   assign hold_lim = cfg_q[CFG_EXTH] ? HOLD_EXT_CYC : HOLD_NORM_CYC;

   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         hold_cnt_q <= 4'h0;
         sda_oe_o   <= 1'b0;
         scl_oe_o   <= 1'b0;
         sda_o      <= 1'b0;
         scl_o      <= 1'b0;
      end else if (!en) begin
         hold_cnt_q <= 4'h0;
         sda_oe_o   <= 1'b0;
         scl_oe_o   <= 1'b0;
      end else begin
         scl_oe_o <= scl_req_low_i;
         if (sda_req_low_i == sda_oe_o) begin
            hold_cnt_q <= 4'h0;
         end else if (hold_cnt_q == hold_lim - 4'h1) begin
            hold_cnt_q <= 4'h0;
            sda_oe_o   <= sda_req_low_i;
         end else begin
            hold_cnt_q <= hold_cnt_q + 4'h1;
         end
      end
   end

   // Read data valid in the cycle after the strobe only
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rdata_o <= 8'h00;
         busy_o  <= 1'b0;
      end else begin
         busy_o  <= busy_q;
         rdata_o <= 8'h00;
         if (rd_i) begin
            case (addr_i)
               ADDR_CFG:    rdata_o <= (cfg_q & CFG_RW_MASK)
                                       | {2'b00, busy_q, 5'b00000};
               ADDR_STAT:   rdata_o <= {4'h0, stat_q};
               ADDR_MASK:   rdata_o <= {4'h0, mask_q};
               ADDR_TCTL:   rdata_o <= {6'h00, tctl_q};
               ADDR_RLD_LO: rdata_o <= rld_lo_q;
               ADDR_RLD_HI: rdata_o <= rld_hi_q;
               ADDR_TMR_LO: rdata_o <= tmr_q[7:0];
               ADDR_TMR_HI: rdata_o <= tmr_q[15:8];
               default:     rdata_o <= 8'h00;
            endcase
         end
      end
   end

   // Checks
   sequence s_ext_req;
      en && cfg_q[CFG_EXTH] && !wr_cfg
      && sda_req_low_i != sda_oe_o && hold_cnt_q == 4'h0;
   endsequence

   sequence s_req_kept;
      (en && !wr_cfg && $stable(sda_req_low_i))[*5];
   endsequence

   a_start_busy: assert property (
      start_det |=> busy_q ##1 busy_o)
      else $error("start seen but busy not raised");

   a_slave_inhibit: assert property (
      cfg_q[CFG_INH] && !stat_q[IRQ_SLAVE] |=> !stat_q[IRQ_SLAVE])
      else $error("slave event flagged while inhibited");

   a_master_flag: assert property (
      en && master_event_i |=> stat_q[IRQ_MASTER])
      else $error("master event not flagged");

   a_busy_readback: assert property (
      rd_i && addr_i == ADDR_CFG |=> rdata_o[CFG_BUSY] == $past(busy_q))
      else $error("busy bit does not read back");

   a_busy_clear: assert property (
      (stop_det || free_pls) |=> !busy_q)
      else $error("busy not cleared by stop or free timeout");

   a_hold_extend: assert property (
      s_ext_req ##1 s_req_kept |=> $changed(sda_oe_o))
      else $error("extended sda hold time wrong");

   a_reload_full: assert property (
      force_rld && !tctl_q[TCTL_SPLIT] && !wr_i
      |=> tmr_q == {rld_hi_q, rld_lo_q})
      else $error("timer not held in reload while scl high");

   a_reload_split: assert property (
      force_rld && tctl_q[TCTL_SPLIT] && !tmr_tick_i && !wr_i
      |=> tmr_q[15:8] == rld_hi_q && $stable(tmr_q[7:0]))
      else $error("split mode reload touched low byte");

   a_free_timeout: assert property (
      free_pls |-> $past(free_cnt_q) >= 4'h9 && scl_s2_q && sda_s2_q)
      else $error("bus free declared too early");

   // Other unmasked status bits may raise irq as well, so only demand it
   a_timeout_flag: assert property (
      hi_ovf |=> stat_q[IRQ_SCLTO]
      ##1 (irq_o || !$past(mask_q[IRQ_SCLTO])))
      else $error("scl timeout overflow not flagged");

   a_release_off: assert property (
      !en |=> !sda_oe_o && !scl_oe_o)
      else $error("line driven while disabled");

endmodule
`default_nettype wire
